// File: rtl/psimd_pkg.sv
// Shared constants, operation codes and request carrier of the packed SIMD ALU
package psimd_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned DATA_W      = 128;
  localparam int unsigned HALF_W      = 64;
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned DWORD_W     = 32;
  localparam int unsigned NUM_BYTES   = 16;
  localparam int unsigned NUM_WORDS   = 8;
  localparam int unsigned NUM_DWORDS  = 4;
  localparam int unsigned NUM_QWORDS  = 2;
  localparam int unsigned BYTES_PER_Q = 8;
  localparam int unsigned IMM_W       = 8;

  // ****************************************************************
  // Behaviour constants and reset values
  // ****************************************************************
  localparam logic [0:0]        AVG_CARRY_IN    = 1'h1;
  localparam logic [IMM_W-1:0]  SHIFT_MAX_BYTES = 8'h0F;
  localparam logic [DATA_W-1:0] RESULT_RESET    = 128'h0;

  // ****************************************************************
  // Operation codes
  // ****************************************************************
  typedef enum logic [3:0] {
    max_signed_word_op        = 4'h0,
    min_signed_word_op        = 4'h1,
    max_unsigned_byte_op      = 4'h2,
    min_unsigned_byte_op      = 4'h3,
    mul_high_unsigned_word_op = 4'h4,
    mul_high_signed_word_op   = 4'h5,
    sum_abs_diff_byte_op      = 4'h6,
    avg_byte_op               = 4'h7,
    avg_word_op               = 4'h8,
    mul_add_word_op           = 4'h9,
    dword_unsigned_mul_op     = 4'hA,
    quad_add_op               = 4'hB,
    quad_sub_op               = 4'hC,
    byte_shift_left_op        = 4'hD,
    byte_shift_right_op       = 4'hE
  } psimd_op_e;

  // Decoded instruction as issued by the pipeline
  typedef struct packed {
    psimd_op_e          op;
    logic               wide;     // 1: 128-bit form, 0: 64-bit form
    logic               src_mem;  // 1: source from memory operand
    logic [IMM_W-1:0]   imm;      // byte count for whole-register shifts
    logic [DATA_W-1:0]  dst;
    logic [DATA_W-1:0]  src_reg;
    logic [DATA_W-1:0]  src_mem_data;
  } psimd_req_s;

endpackage : psimd_pkg

// File: rtl/psimd_alu.sv
// Packed integer SIMD execution datapath with one registered result stage
// What this block does
// - Signed word max: per 16-bit lane, larger signed value.
// - Signed word min: per 16-bit lane, smaller signed value.
// - Unsigned byte max/min: per byte lane, larger or smaller value.
// - Multiply high: word products, unsigned or signed, keep upper 16 bits.
// - Byte absolute differences summed into low word; upper three words cleared.
// - Average: a plus b plus carry-in, shifted right, carry into top bit.
// - Byte average on unsigned bytes, word average on unsigned words.
// - Destination is a register; source from register or memory operand.
// - Multiply-add: signed word pairs multiplied, adjacent products summed to dwords.
// - Low dword of each 64-bit chunk multiplied unsigned, full 64-bit product.
// - Dword multiply, quad add/sub in 64 or two independent 64-bit halves.
// - Quad add/sub identical for unsigned and two's-complement operands.
// - Quad add/sub keep the low 64 bits, wrapping, no flags.
// - Byte shifts move by immediate byte count, zero-filling vacated bytes.
// - Byte shift count above 15 gives an all-zero result.
module psimd_alu (
  // Clock, reset, enable
  input  wire logic                     clk_sys_in,
  input  wire logic                     reset_n_in,
  input  wire logic                     ce_in,
  // Issue side
  input  wire logic                     req_valid_in,
  input  wire psimd_pkg::psimd_req_s    req_in,
  // Result side
  output logic                          res_valid_out,
  output logic [psimd_pkg::DATA_W-1:0]  res_data_out
);

  // ****************************************************************
  // Operand selection
  // ****************************************************************
  // Destination operand always comes from the register file
  logic [psimd_pkg::DATA_W-1:0] a_w;
  logic [psimd_pkg::DATA_W-1:0] b_w;
  assign a_w = req_in.dst;
  assign b_w = req_in.src_mem ? req_in.src_mem_data : req_in.src_reg;

  // Sum of absolute byte differences over one 64-bit chunk
  function automatic logic [15:0] sad_chunk(input logic [63:0] x, input logic [63:0] y);
    logic [15:0] acc;
    logic [7:0]  d;
    acc = 16'h0;
    d   = 8'h0;
    for (int k = 0; k < psimd_pkg::BYTES_PER_Q; k++) begin
      d   = (x[k*8 +: 8] > y[k*8 +: 8]) ? (x[k*8 +: 8] - y[k*8 +: 8])
                                        : (y[k*8 +: 8] - x[k*8 +: 8]);
      acc = acc + {8'h0, d};
    end
    return acc;
  endfunction : sad_chunk

  // ****************************************************************
  // Byte lanes
  // ****************************************************************
  logic [psimd_pkg::DATA_W-1:0] max_ub_w;
  logic [psimd_pkg::DATA_W-1:0] min_ub_w;
  logic [psimd_pkg::DATA_W-1:0] avg_b_w;
  for (genvar i = 0; i < psimd_pkg::NUM_BYTES; i++) begin : g_byte
    logic [7:0] ab;
    logic [7:0] bb;
    logic [8:0] sum;
    assign ab  = a_w[i*8 +: 8];
    assign bb  = b_w[i*8 +: 8];
    // Nine-bit sum keeps the carry for the top bit after the shift
    assign sum = {1'h0, ab} + {1'h0, bb} + {8'h0, psimd_pkg::AVG_CARRY_IN};
    assign max_ub_w[i*8 +: 8] = (ab > bb) ? ab : bb;
    assign min_ub_w[i*8 +: 8] = (ab < bb) ? ab : bb;
    assign avg_b_w[i*8 +: 8]  = sum[8:1];
  end

  // ****************************************************************
  // Word lanes
  // ****************************************************************
  logic [psimd_pkg::DATA_W-1:0] max_sw_w;
  logic [psimd_pkg::DATA_W-1:0] min_sw_w;
  logic [psimd_pkg::DATA_W-1:0] mulhu_w;
  logic [psimd_pkg::DATA_W-1:0] mulhs_w;
  logic [psimd_pkg::DATA_W-1:0] avg_w_w;
  logic [31:0]                  prod_s_w [psimd_pkg::NUM_WORDS];
  for (genvar i = 0; i < psimd_pkg::NUM_WORDS; i++) begin : g_word
    logic        [15:0] aw;
    logic        [15:0] bw;
    logic        [31:0] pu;
    logic        [16:0] sum;
    assign aw  = a_w[i*16 +: 16];
    assign bw  = b_w[i*16 +: 16];
    assign pu  = {16'h0, aw} * {16'h0, bw};
    assign prod_s_w[i] = 32'($signed(aw) * $signed(bw));
    assign sum = {1'h0, aw} + {1'h0, bw} + {16'h0, psimd_pkg::AVG_CARRY_IN};
    // Signed compare stays inside the lane
    assign max_sw_w[i*16 +: 16] = ($signed(aw) > $signed(bw)) ? aw : bw;
    assign min_sw_w[i*16 +: 16] = ($signed(aw) < $signed(bw)) ? aw : bw;
    assign mulhu_w[i*16 +: 16]  = pu[31:16];
    assign mulhs_w[i*16 +: 16]  = prod_s_w[i][31:16];
    assign avg_w_w[i*16 +: 16]  = sum[16:1];
  end

  // ****************************************************************
  // Doubleword lanes: multiply-add of adjacent word products
  // ****************************************************************
  logic [psimd_pkg::DATA_W-1:0] madd_w;
  for (genvar i = 0; i < psimd_pkg::NUM_DWORDS; i++) begin : g_dword
    // Only 8000h*8000h twice can overflow; it wraps like the hardware sum
    assign madd_w[i*32 +: 32] = prod_s_w[2*i] + prod_s_w[2*i+1];
  end

  // ****************************************************************
  // Quadword chunks
  // ****************************************************************
  logic [psimd_pkg::DATA_W-1:0] mulq_w;
  logic [psimd_pkg::DATA_W-1:0] addq_w;
  logic [psimd_pkg::DATA_W-1:0] subq_w;
  logic [psimd_pkg::DATA_W-1:0] sad_w;
  for (genvar j = 0; j < psimd_pkg::NUM_QWORDS; j++) begin : g_qword
    // Each chunk works alone, so the 128-bit form is two separate operations
    assign mulq_w[j*64 +: 64] = {32'h0, a_w[j*64 +: 32]} * {32'h0, b_w[j*64 +: 32]};
    // Plain modulo arithmetic: sign does not matter, carry-out is dropped
    assign addq_w[j*64 +: 64] = a_w[j*64 +: 64] + b_w[j*64 +: 64];
    assign subq_w[j*64 +: 64] = a_w[j*64 +: 64] - b_w[j*64 +: 64];
    assign sad_w[j*64 +: 64]  = {48'h0, sad_chunk(a_w[j*64 +: 64], b_w[j*64 +: 64])};
  end

  // ****************************************************************
  // Whole-register byte shifts
  // ****************************************************************
  logic                         shift_over_w;
  logic [6:0]                   shift_bits_w;
  logic [psimd_pkg::DATA_W-1:0] shl_w;
  logic [psimd_pkg::DATA_W-1:0] shr_w;
  assign shift_over_w = (req_in.imm > psimd_pkg::SHIFT_MAX_BYTES);
  assign shift_bits_w = {req_in.imm[3:0], 3'h0};
  assign shl_w = shift_over_w ? psimd_pkg::RESULT_RESET : (a_w << shift_bits_w);
  assign shr_w = shift_over_w ? psimd_pkg::RESULT_RESET : (a_w >> shift_bits_w);

  // ****************************************************************
  // Result selection and width masking
  // ****************************************************************
  logic [psimd_pkg::DATA_W-1:0] sel_w;
  logic [psimd_pkg::DATA_W-1:0] res_d;
  logic                         is_shift_w;
  assign is_shift_w = (req_in.op == psimd_pkg::byte_shift_left_op) ||
                      (req_in.op == psimd_pkg::byte_shift_right_op);
  assign sel_w =
    (req_in.op == psimd_pkg::max_signed_word_op)        ? max_sw_w :
    (req_in.op == psimd_pkg::min_signed_word_op)        ? min_sw_w :
    (req_in.op == psimd_pkg::max_unsigned_byte_op)      ? max_ub_w :
    (req_in.op == psimd_pkg::min_unsigned_byte_op)      ? min_ub_w :
    (req_in.op == psimd_pkg::mul_high_unsigned_word_op) ? mulhu_w  :
    (req_in.op == psimd_pkg::mul_high_signed_word_op)   ? mulhs_w  :
    (req_in.op == psimd_pkg::sum_abs_diff_byte_op)      ? sad_w    :
    (req_in.op == psimd_pkg::avg_byte_op)               ? avg_b_w  :
    (req_in.op == psimd_pkg::avg_word_op)               ? avg_w_w  :
    (req_in.op == psimd_pkg::mul_add_word_op)           ? madd_w   :
    (req_in.op == psimd_pkg::dword_unsigned_mul_op)     ? mulq_w   :
    (req_in.op == psimd_pkg::quad_add_op)               ? addq_w   :
    (req_in.op == psimd_pkg::quad_sub_op)               ? subq_w   :
    (req_in.op == psimd_pkg::byte_shift_left_op)        ? shl_w    :
    (req_in.op == psimd_pkg::byte_shift_right_op)       ? shr_w    :
                                                          psimd_pkg::RESULT_RESET;
  // 64-bit forms leave the upper half clear; shifts are always full width
  assign res_d = (req_in.wide || is_shift_w) ? sel_w
                                             : {64'h0, sel_w[63:0]};

  // ****************************************************************
  // Result register
  // ****************************************************************
  // Data only loads on a valid issue to save toggling
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      res_valid_out <= 1'h0;
      res_data_out  <= psimd_pkg::RESULT_RESET;
    end else if (ce_in) begin
      res_valid_out <= req_valid_in;
      if (req_valid_in) begin
        res_data_out <= res_d;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Copy of the issued operands, read only by the properties below
  psimd_pkg::psimd_op_e         op_q;
  logic                         wide_q;
  logic [psimd_pkg::IMM_W-1:0]  imm_q;
  logic [psimd_pkg::DATA_W-1:0] a_q;
  logic [psimd_pkg::DATA_W-1:0] b_q;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      op_q   <= psimd_pkg::max_signed_word_op;
      wide_q <= 1'h0;
      imm_q  <= 8'h00;
      a_q    <= psimd_pkg::RESULT_RESET;
      b_q    <= psimd_pkg::RESULT_RESET;
    end else if (ce_in && req_valid_in) begin
      op_q   <= req_in.op;
      wide_q <= req_in.wide;
      imm_q  <= req_in.imm;
      a_q    <= a_w;
      b_q    <= b_w;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  a_max_sword: assert property (res_valid_out && op_q == psimd_pkg::max_signed_word_op |->
    !($signed(res_data_out[31:16]) < $signed(a_q[31:16])) &&
    !($signed(res_data_out[31:16]) < $signed(b_q[31:16])) &&
    (res_data_out[31:16] == a_q[31:16] || res_data_out[31:16] == b_q[31:16]))
    else $error("signed word max lane wrong");
  a_min_sword: assert property (res_valid_out && op_q == psimd_pkg::min_signed_word_op |->
    !($signed(res_data_out[15:0]) > $signed(a_q[15:0])) &&
    !($signed(res_data_out[15:0]) > $signed(b_q[15:0])) &&
    (res_data_out[15:0] == a_q[15:0] || res_data_out[15:0] == b_q[15:0]))
    else $error("signed word min lane wrong");
  a_max_ubyte: assert property (res_valid_out && op_q == psimd_pkg::max_unsigned_byte_op |->
    res_data_out[47:40] >= a_q[47:40] && res_data_out[47:40] >= b_q[47:40] &&
    (res_data_out[47:40] == a_q[47:40] || res_data_out[47:40] == b_q[47:40]))
    else $error("unsigned byte max lane wrong");
  a_mulh_word: assert property (res_valid_out && op_q == psimd_pkg::mul_high_unsigned_word_op |->
    res_data_out[47:32] == 16'(({16'h0, a_q[47:32]} * {16'h0, b_q[47:32]}) >> 16))
    else $error("unsigned multiply high wrong");
  a_sad_upper: assert property (res_valid_out && op_q == psimd_pkg::sum_abs_diff_byte_op |->
    res_data_out[63:16] == 48'h0 && (res_data_out[15:0] != 16'h0 || a_q[63:0] == b_q[63:0]))
    else $error("sad upper words not clear");
  a_avg_byte: assert property (res_valid_out && op_q == psimd_pkg::avg_byte_op |->
    res_data_out[7:0] == 8'(({1'h0, a_q[7:0]} + {1'h0, b_q[7:0]} + 9'h001) >> 1))
    else $error("byte average wrong");
  a_quad_wrap: assert property (res_valid_out && op_q == psimd_pkg::quad_sub_op |->
    res_data_out[63:0] + b_q[63:0] == a_q[63:0])
    else $error("quad subtract not modulo");
  a_shift_zero: assert property (res_valid_out && op_q == psimd_pkg::byte_shift_left_op &&
    imm_q > 8'h0F |-> res_data_out == 128'h0)
    else $error("oversized shift not zero");
  a_narrow_half: assert property (res_valid_out && !wide_q &&
    op_q != psimd_pkg::byte_shift_left_op && op_q != psimd_pkg::byte_shift_right_op |->
    res_data_out[127:64] == 64'h0)
    else $error("64-bit form upper half not clear");
  a_valid_next: assert property (ce_in && req_valid_in |=> res_valid_out)
    else $error("result valid missing");

  c_shift_over: cover property (res_valid_out && op_q == psimd_pkg::byte_shift_right_op &&
    imm_q > 8'h0F);
  c_sad_wide:   cover property (res_valid_out && op_q == psimd_pkg::sum_abs_diff_byte_op && wide_q);
  c_avg_mem:    cover property (ce_in && req_valid_in && req_in.op == psimd_pkg::avg_word_op &&
    req_in.src_mem);

endmodule : psimd_alu

// File: testbench/psimd_issue_model.sv
// Behavioural model of the pipeline stage that issues decoded requests to the ALU
module psimd_issue_model (
  // Clock
  input  wire logic             clk_sys_in,
  // Issue side
  output psimd_pkg::psimd_req_s req_out,
  output logic                  req_valid_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // Quiet at time zero
  initial begin
    req_valid_out = 1'b0;
    req_out       = '0;
  end

  // Present one request for one cycle, changed just after the edge
  task automatic send(input psimd_pkg::psimd_req_s r);
    @(posedge clk_sys_in);
    req_valid_out <= 1'b1;
    req_out       <= r;
  endtask : send

  // Idle cycle: the request word is inverted so a design ignoring valid shows up
  task automatic idle;
    @(posedge clk_sys_in);
    req_valid_out <= 1'b0;
    req_out       <= psimd_pkg::psimd_req_s'(~req_out);
  endtask : idle
endmodule : psimd_issue_model

// File: testbench/psimd_alu_tb.sv
// Self-checking testbench of the packed SIMD ALU
module psimd_alu_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef logic [psimd_pkg::DATA_W-1:0] psimd_vec_t;
  localparam psimd_vec_t OPA = 128'h80007FFFFF0100801234FEDC00FF8001;
  localparam psimd_vec_t OPB = 128'h7FFF8000FFFE0101CAFE0001FF008000;
  localparam psimd_vec_t OPC = 128'h0F0FA5A5FFFFFFFF3C3C000000000001;

  // ****************************************************************
  // Clock, design and issue model
  // ****************************************************************
  logic                  clk_sys_in;
  logic                  reset_n_in;
  logic                  ce_in;
  logic                  req_valid;
  psimd_pkg::psimd_req_s req;
  logic                  res_valid;
  psimd_vec_t            res_data;
  psimd_vec_t            exp_d;
  bit                    pend;
  int                    errors;
  int                    total_checks;

  // Free-running system clock
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  psimd_issue_model pm (.clk_sys_in(clk_sys_in), .req_out(req), .req_valid_out(req_valid));
  psimd_alu dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
    .req_valid_in(req_valid), .req_in(req), .res_valid_out(res_valid), .res_data_out(res_data));

  // ****************************************************************
  // Reference, compares and issue helpers
  // ****************************************************************
  // Expected result built lane by lane, independent of the design
  function automatic psimd_vec_t ref_f(psimd_pkg::psimd_req_s r);
    psimd_vec_t  a;
    psimd_vec_t  b;
    psimd_vec_t  y;
    logic [15:0] x;
    logic [15:0] w;
    logic [31:0] p;
    logic [15:0] acc [2];
    a = r.dst;
    b = r.src_mem ? r.src_mem_data : r.src_reg;
    y = '0;
    acc = '{16'h0, 16'h0};
    for (int k = 0; k < 8; k++) begin
      x = a[16*k+:16];
      w = b[16*k+:16];
      // Separate branches keep the signed product from being widened as unsigned
      if (r.op == psimd_pkg::mul_high_signed_word_op) p = $signed(x) * $signed(w);
      else p = x * w;
      case (r.op)
        psimd_pkg::max_signed_word_op: y[16*k+:16] = ($signed(x) > $signed(w)) ? x : w;
        psimd_pkg::min_signed_word_op: y[16*k+:16] = ($signed(x) < $signed(w)) ? x : w;
        psimd_pkg::mul_high_unsigned_word_op,
        psimd_pkg::mul_high_signed_word_op: y[16*k+:16] = p[31:16];
        psimd_pkg::avg_word_op: y[16*k+:16] = (x + w + 32'h1) >> 1;
        default: ;
      endcase
    end
    for (int k = 0; k < 16; k++) begin
      x = {8'h00, a[8*k+:8]};
      w = {8'h00, b[8*k+:8]};
      case (r.op)
        psimd_pkg::max_unsigned_byte_op: y[8*k+:8] = (x > w) ? x[7:0] : w[7:0];
        psimd_pkg::min_unsigned_byte_op: y[8*k+:8] = (x < w) ? x[7:0] : w[7:0];
        psimd_pkg::avg_byte_op: y[8*k+:8] = (x + w + 32'h1) >> 1;
        psimd_pkg::sum_abs_diff_byte_op: acc[k/8] += (x > w) ? x - w : w - x;
        default: ;
      endcase
    end
    for (int k = 0; k < 4; k++) begin
      if (r.op == psimd_pkg::mul_add_word_op) y[32*k+:32] =
        $signed(a[32*k+:16]) * $signed(b[32*k+:16]) +
        $signed(a[32*k+16+:16]) * $signed(b[32*k+16+:16]);
    end
    for (int k = 0; k < 2; k++) begin
      case (r.op)
        psimd_pkg::dword_unsigned_mul_op: y[64*k+:64] = a[64*k+:32] * b[64*k+:32];
        psimd_pkg::quad_add_op: y[64*k+:64] = a[64*k+:64] + b[64*k+:64];
        psimd_pkg::quad_sub_op: y[64*k+:64] = a[64*k+:64] - b[64*k+:64];
        psimd_pkg::sum_abs_diff_byte_op: y[64*k+:16] = acc[k];
        default: ;
      endcase
    end
    if (r.op == psimd_pkg::byte_shift_left_op) y = (r.imm > 15) ? '0 : a << (8 * r.imm);
    if (r.op == psimd_pkg::byte_shift_right_op) y = (r.imm > 15) ? '0 : a >> (8 * r.imm);
    if (!r.wide && r.op < psimd_pkg::byte_shift_left_op) y[127:64] = '0;
    return y;
  endfunction : ref_f

  task automatic chk_v(input logic e);
    total_checks++;
    if (res_valid !== e) begin
      errors++;
      $display("Error at %0t: result valid %b, expected %b", $time, res_valid, e);
    end
  endtask : chk_v

  task automatic chk_d(input psimd_vec_t e);
    total_checks++;
    if (res_data !== e) begin
      errors++;
      $display("Error at %0t: result %h, expected %h", $time, res_data, e);
    end
  endtask : chk_d

  // Issue one request and judge the one issued on the previous edge, which the design takes on this edge
  task automatic run(input psimd_pkg::psimd_req_s r);
    pm.send(r);
    #1;
    chk_v(pend);
    if (pend) chk_d(exp_d);
    pend  = 1'b1;
    exp_d = ref_f(r);
  endtask : run

  task automatic flush;
    pm.idle();
    #1;
    chk_v(pend);
    if (pend) chk_d(exp_d);
    pend = 1'b0;
  endtask : flush

  // Every operation code, the unused one too, in both widths, source select toggled
  task automatic t_ops(input psimd_vec_t a, input psimd_vec_t b, input psimd_vec_t m);
    for (int i = 0; i < 16; i++) begin
      for (int w = 0; w < 2; w++) begin
        run('{op: psimd_pkg::psimd_op_e'(i), wide: w[0], src_mem: w[0] ^ i[0], imm: 8'h05,
              dst: a, src_reg: b, src_mem_data: m});
      end
    end
    flush();
  endtask : t_ops

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_shift;
    logic [7:0] cnt [6] = '{8'h00, 8'h01, 8'h08, 8'h0F, 8'h10, 8'hFF};
    for (int k = 0; k < 12; k++) begin
      run('{op: k[0] ? psimd_pkg::byte_shift_right_op : psimd_pkg::byte_shift_left_op,
            wide: k[1], src_mem: 1'b0, imm: cnt[k/2], dst: OPA, src_reg: OPB, src_mem_data: OPC});
    end
    flush();
  endtask : t_shift

  // Clock enable low freezes the result while requests keep coming
  task automatic t_hold;
    run('{op: psimd_pkg::quad_add_op, wide: 1'b1, src_mem: 1'b0, imm: 8'h00, dst: OPA,
          src_reg: OPB, src_mem_data: OPC});
    pm.idle();
    ce_in <= 1'b0;
    #1;
    chk_v(1'b1);
    chk_d(exp_d);
    repeat (2) begin
      pm.send('{op: psimd_pkg::quad_sub_op, wide: 1'b1, src_mem: 1'b1, imm: 8'h00, dst: OPB,
                src_reg: OPA, src_mem_data: OPC});
      #1;
      chk_v(1'b1);
      chk_d(exp_d);
    end
    pm.idle();
    ce_in <= 1'b1;
    #1;
    chk_d(exp_d);
    pend = 1'b0;
    pm.idle();
    #1;
    chk_v(1'b0);
    chk_d(exp_d);
  endtask : t_hold

  // Reset in mid-run clears the result stage
  task automatic t_reset;
    // Issued twice so reset lands on a valid result that was already judged once
    repeat (2) begin
      run('{op: psimd_pkg::avg_byte_op, wide: 1'b1, src_mem: 1'b1, imm: 8'h00, dst: OPA,
            src_reg: OPB, src_mem_data: OPC});
    end
    pm.idle();
    reset_n_in <= 1'b0;
    #1;
    chk_v(1'b0);
    chk_d(psimd_pkg::RESULT_RESET);
    pm.idle();
    reset_n_in <= 1'b1;
    pend = 1'b0;
    flush();
  endtask : t_reset

  task automatic stop_test;
    if (errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test

  // Main sequence
  initial begin
    errors = 0;
    total_checks = 0;
    pend = 1'b0;
    exp_d = '0;
    reset_n_in = 1'b0;
    ce_in = 1'b1;
    repeat (12) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    flush();
    t_ops(OPA, OPB, OPC);
    t_ops({4{32'h80007FFF}}, {8{16'h8000}}, {16{8'hFF}});
    t_ops({2{64'hFFFFFFFFFFFFFFFF}}, {2{64'h1}}, {2{64'hFFFFFFFF00000002}});
    t_shift();
    t_hold();
    t_reset();
    stop_test();
  end

  // Watchdog well beyond the 136 cycles the scenarios take
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    errors++;
    stop_test();
  end
endmodule : psimd_alu_tb
